/* tx_dma_descriptor_error_recovery_test.sv */
// self-checking bench of the transmit descriptor engine
`timescale 1ns/1ps
`include "tx_dma_map.svh"
module tx_dma_descriptor_error_recovery_test;
   import tx_dma_pkg::*;
   logic clk_sys, rst, reg_wr, reg_rd, pq_valid, pq_ready, pq_restart, mem_req, mem_we, mem_ack, mem_err;
   logic tx_valid, tx_ready, tx_last, fifo_underflow, dq_valid, dq_ready, uf_arm;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, err_addr, base, rs, rn, d, b1, b2, b3;
   logic [7:0] pq_channel, tx_byte, tx_channel, dq_channel;
   desc_index_t pq_index, dq_index;
   done_status_t dq_status;
   logic [16:0] txq[$];
   logic [26:0] dqq[$];
   int mismatches, n_tests, cyc;
   tx_dma_engine u_dut (.*);
   tx_host_mem u_mem (.*);
   initial begin
      clk_sys = 0;
      forever #10 clk_sys = ~clk_sys;
   end
   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xs
   function automatic logic [7:0] bat(logic [31:0] a);
      logic [31:0] w;
      w = u_mem.mem[{a[31:2], 2'b00}];
      return w[8*a[1:0] +: 8];
   endfunction : bat
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(logic [11:0] a, logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 0;
   endtask : wr
   task automatic rd(logic [11:0] a);
      @(posedge clk_sys);
      reg_rd <= 1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 0;
      #1 d = reg_rdata;
   endtask : rd
   // host writes the pending link fields as zero and junk in ignored bits
   task automatic desc(int i, logic [31:0] b, int n, logic l, logic c, int nx, logic [7:0] ch);
      logic [31:0] a;
      a = base + 16 * i;
      for (int k = 0; k <= n / 4 + 1; k++) u_mem.mem[{b[31:2], 2'b00} + 4 * k] = xs();
      u_mem.mem[a] = b;
      u_mem.mem[a + 4] = {l, c, 1'b1, n[12:0], nx[15:0]};
      u_mem.mem[a + 8] = (xs() & 32'hffffff00) | ch;
      u_mem.mem[a + 12] = xs() & 32'hfffc0000;
   endtask : desc
   task automatic pq(int i, logic [7:0] ch, logic r, logic h = 1'b0);
      int t;
      t = 0;
      // a held entry is replaced right after the edge that took it, so the slots fill with no idle gap
      if (pq_valid !== 1'b1) @(posedge clk_sys);
      pq_valid <= 1; pq_index <= i[15:0]; pq_channel <= ch; pq_restart <= r;
      #1;
      while (pq_ready !== 1'b1 && t < 3000) begin
         @(posedge clk_sys) #1;
         t++;
      end
      @(posedge clk_sys);
      if (!h) pq_valid <= 0;
   endtask : pq
   task automatic wdq(int n);
      int t;
      t = 0;
      while (dqq.size() < n && t < 4000) begin
         @(posedge clk_sys);
         t++;
      end
      repeat (6) @(posedge clk_sys);
      chk(dqq.size(), n);
   endtask : wdq
   task automatic edq(logic [7:0] ch, done_status_t s, desc_index_t i);
      chk(dqq.size() ? dqq.pop_front() : 'x, {i, ch, s});
   endtask : edq
   task automatic ebuf(logic [31:0] b, int n, logic l = 1'b0, logic [7:0] ch = 8'h05);
      for (int k = 0; k < n; k++) chk(txq.size() ? txq.pop_front() : 'x, {ch, l && k == n - 1, bat(b + k)});
   endtask : ebuf
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   // ****************************************************************
   // sinks, underflow source and watchdog
   // ****************************************************************
   always @(posedge clk_sys) begin
      if (tx_valid && tx_ready) txq.push_back({tx_channel, tx_last, tx_byte});
      if (dq_valid && dq_ready) dqq.push_back({dq_index, dq_channel, dq_status});
      rn = xs();
      tx_ready <= rn[0] | rn[1];
      dq_ready <= rn[2] | rn[3];
      fifo_underflow <= uf_arm && tx_valid;
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         results();
      end
   end
   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      rs = 78; cyc = 0; mismatches = 0; n_tests = 0;
      {rst, reg_wr, reg_rd, pq_valid, pq_restart, uf_arm} = 6'h20;
      reg_addr = 12'h0; reg_wdata = 32'h0; pq_index = 16'h0; pq_channel = 8'h0; err_addr = '1;
      repeat (3) @(posedge clk_sys);
      rst <= 0;
      base = xs() & 32'h7ff0fff0;
      b1 = base + 32'h00100003; b2 = b1 + 32'h101; b3 = b1 + 32'h202;
      wr(`OFS_BASE_LOW, {16'hffff, base[15:0]});
      wr(`OFS_BASE_HIGH, {16'hffff, base[31:16]});
      rd(`OFS_BASE_LOW); chk(d, {16'h0, base[15:0]});
      rd(`OFS_BASE_HIGH); chk(d, {16'h0, base[31:16]});
      rd(12'h8f0); chk(d, 32'h0);
      wr(`OFS_CHAN_ENABLE, 32'h105);
      // two buffers then a second packet through the chain flag
      desc(1, b1, 3, 0, 1, 2, 8'h05);
      desc(2, b2, 5, 1, 1, 7, 8'h05);
      desc(7, b3, 2, 1, 0, 0, 8'h05);
      pq(1, 8'h05, 0);
      wdq(2);
      edq(8'h05, `ST_PACKET_OK, 16'h2); edq(8'h05, `ST_PACKET_OK, 16'h7);
      ebuf(b1, 3); ebuf(b2, 5, 1); ebuf(b3, 2, 1);
      $display("chains done");
      // disabled channel 256, then restart flag brings it back
      desc(3, b1, 4, 1, 0, 0, 8'hff);
      pq(3, 8'hff, 0);
      wdq(1);
      edq(8'hff, `ST_NOT_ENABLED, 16'h3); chk(txq.size(), 0);
      pq(3, 8'hff, 1);
      wdq(1);
      edq(8'hff, `ST_PACKET_OK, 16'h3); ebuf(b1, 4, 1, 8'hff);
      // the enable port reads the channel last selected by a write, still channel 5 here
      rd(`OFS_CHAN_ENABLE); chk(d, 32'h105);
      $display("restart done");
      // zero byte count disables the channel
      desc(4, b1, 0, 1, 0, 0, 8'h05);
      pq(4, 8'h05, 0);
      wdq(1);
      edq(8'h05, `ST_DESC_ERROR, 16'h4);
      wr(`OFS_CHAN_ENABLE, 32'h005); rd(`OFS_CHAN_ENABLE); chk(d, 32'h005);
      $display("zero count done");
      // bus fault on the second data byte, rest of the chain is skipped
      desc(5, b2, 2, 0, 0, 6, 8'h05);
      desc(6, b3, 2, 1, 0, 0, 8'h05);
      err_addr = b2 + 1;
      pq(5, 8'h05, 1);
      wdq(2);
      edq(8'h05, `ST_BUS_ERROR, 16'h5); edq(8'h05, `ST_NOT_ENABLED, 16'h6);
      err_addr = '1;
      txq.delete();
      $display("fault done");
      // earlier queued work drains before the restart takes effect
      desc(8, b1, 3, 1, 0, 0, 8'h05);
      desc(9, b2, 3, 1, 0, 0, 8'h05);
      pq(8, 8'h05, 0);
      pq(9, 8'h05, 1);
      wdq(2);
      edq(8'h05, `ST_NOT_ENABLED, 16'h8); edq(8'h05, `ST_PACKET_OK, 16'h9);
      uf_arm = 1;
      pq(9, 8'h05, 0);
      wdq(1);
      uf_arm = 0;
      edq(8'h05, `ST_UNDERFLOW, 16'h9);
      txq.delete();
      $display("recovery done");
      // three chains in a row, the third one linked outside; host re-enables by hand first
      wr(`OFS_CHAN_ENABLE, 32'h105);
      desc(10, b3, 2, 1, 0, 0, 8'h05);
      desc(9, b2, 3, 1, 0, 0, 8'h05);
      desc(8, b1, 3, 1, 0, 0, 8'h05);
      pq(8, 8'h05, 0, 1); pq(9, 8'h05, 0, 1); pq(10, 8'h05, 0);
      wdq(3);
      for (int k = 0; k < 3; k++) edq(8'h05, `ST_PACKET_OK, 16'h8 + k[15:0]);
      ebuf(b1, 3, 1); ebuf(b2, 3, 1); ebuf(b3, 2, 1);
      $display("linking done");
      results();
   end
endmodule : tx_dma_descriptor_error_recovery_test

/* tx_dma_engine.sv */
// transmit descriptor engine: chain walking, external chain linking, done-queue posting and error recovery
`timescale 1ns/1ps
`include "tx_dma_map.svh"
module tx_dma_engine #(
   parameter int CHANNELS = 256,
   parameter int COUNT_W = 13
) (
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic [11:0] reg_addr, // register address
   input wire logic [31:0] reg_wdata, // register write data
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   output logic [31:0] reg_rdata, // read data, cycle after the strobe
   input wire logic pq_valid, // pending-queue entry offered
   output logic pq_ready, // pending-queue entry taken
   input wire tx_dma_pkg::desc_index_t pq_index, // first descriptor of the chain
   input wire logic [7:0] pq_channel, // channel number minus one
   input wire logic pq_restart, // channel_restart_flag
   output logic mem_req, // memory access request
   output logic mem_we, // memory write
   output logic [31:0] mem_addr, // memory byte address
   output logic [31:0] mem_wdata, // memory write data
   input wire logic mem_ack, // access complete
   input wire logic mem_err, // parity or abort with the ack
   input wire logic [31:0] mem_rdata, // read data with the ack
   output logic tx_valid, // data byte offered
   input wire logic tx_ready, // data byte taken
   output logic [7:0] tx_byte, // data byte
   output logic [7:0] tx_channel, // channel of the byte
   output logic tx_last, // last byte of the packet
   input wire logic fifo_underflow, // transmit FIFO ran dry
   output logic dq_valid, // done-queue entry offered
   input wire logic dq_ready, // done-queue entry taken
   output tx_dma_pkg::desc_index_t dq_index, // descriptor posted
   output logic [7:0] dq_channel, // its channel
   output tx_dma_pkg::done_status_t dq_status // its status
);
   import tx_dma_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   dma_state_t state_q;
   logic [15:0] base_lo_q, base_hi_q;
   logic per_buffer_q;
   logic [CHANNELS-1:0] channel_enable_bit_q;
   logic [7:0] channel_enable_bit_sel_q;
   logic s0_valid_q, s0_restart_q, s0_check_q, s1_valid_q, s1_restart_q, s1_check_q;
   desc_index_t s0_index_q, s1_index_q, tail_q, link_index_q, cur_q;
   logic [7:0] s0_ch_q, s1_ch_q;
   logic link_restart_q;
   logic [15:0] ext_q;
   logic [1:0] word_q;
   logic [31:0] dw0_q, dw1_q, dw2_q, dw3_q;
   logic first_q, check_q, mid_q, abort_q, have_q, post_q;
   logic [COUNT_W-1:0] off_q;
   done_status_t status_q;
   logic [31:0] rdata_q;

   logic [31:0] base;
   logic [COUNT_W-1:0] count;
   logic [7:0] chan;
   logic last_buf, chain_next, last_byte, pq_take;

   assign base = {base_hi_q, base_lo_q};
   assign count = dw1_q[`D1_COUNT_MSB:`D1_COUNT_LSB];
   assign chan = dw2_q[7:0];
   assign last_buf = dw1_q[`D1_LAST_BIT];
   assign chain_next = dw1_q[`D1_CHAIN_BIT];
   assign last_byte = off_q == count - 1'b1;
   assign pq_ready = state_q == S_IDLE;
   assign pq_take = pq_valid && pq_ready;

   // ****************************************************************
   // register port
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         base_lo_q <= 16'h0;
         base_hi_q <= 16'h0;
         per_buffer_q <= 1'b0;
         channel_enable_bit_sel_q <= 8'h0;
      end else if (reg_wr) begin
         if (reg_addr == `OFS_BASE_LOW) begin
            base_lo_q <= reg_wdata[15:0];
         end else if (reg_addr == `OFS_BASE_HIGH) begin
            base_hi_q <= reg_wdata[15:0];
         end else if (reg_addr == `OFS_CHAN_ENABLE) begin
            channel_enable_bit_sel_q <= reg_wdata[7:0];
         end else if (reg_addr == `OFS_CONTROL) begin
            per_buffer_q <= reg_wdata[`CTRL_PER_BUFFER_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= 32'h0;
      end else if (!reg_rd) begin
         rdata_q <= 32'h0;
      end else if (reg_addr == `OFS_BASE_LOW) begin
         rdata_q <= {16'h0, base_lo_q};
      end else if (reg_addr == `OFS_BASE_HIGH) begin
         rdata_q <= {16'h0, base_hi_q};
      end else if (reg_addr == `OFS_CHAN_ENABLE) begin
         rdata_q <= {23'h0, channel_enable_bit_q[channel_enable_bit_sel_q], channel_enable_bit_sel_q};
      end else if (reg_addr == `OFS_CONTROL) begin
         rdata_q <= {31'h0, per_buffer_q};
      end else if (reg_addr == `OFS_STATUS) begin
         rdata_q <= {ext_q, 7'h0, status_q, s1_valid_q, s0_valid_q, 1'b0, state_q};
      end else begin
         rdata_q <= 32'h0;
      end
   end
   assign reg_rdata = rdata_q;

   // ****************************************************************
   // channel enable bits
   // ****************************************************************
   // hardware events are applied after the software write so they win in a shared cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         channel_enable_bit_q <= '0;
      end else begin
         if (reg_wr && reg_addr == `OFS_CHAN_ENABLE) begin
            channel_enable_bit_q[reg_wdata[7:0]] <= reg_wdata[`CHANNEL_ENABLE_BIT_VALUE_BIT];
         end
         if (state_q == S_START && s0_restart_q) begin
            channel_enable_bit_q[s0_ch_q] <= 1'b1;
         end
         if (state_q == S_CHECK && (!channel_enable_bit_q[chan] || count == '0 || (check_q && chan != s0_ch_q))) begin
            channel_enable_bit_q[chan] <= 1'b0;
         end
         if ((state_q == S_READ || state_q == S_DATA) && mem_ack && mem_err) begin
            channel_enable_bit_q[chan] <= 1'b0;
         end
         if (state_q == S_DATA && fifo_underflow) begin
            channel_enable_bit_q[chan] <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // memory master
   // ****************************************************************
   always_comb begin
      mem_req = 1'b0;
      mem_we = 1'b0;
      mem_addr = 32'h0;
      mem_wdata = 32'h0;
      if (state_q == S_LINK) begin
         mem_req = 1'b1;
         mem_we = 1'b1;
         mem_addr = base + {12'h0, tail_q, `DW3_OFFSET};
         mem_wdata = {14'h0, link_restart_q, 1'b1, link_index_q};
      end else if (state_q == S_READ) begin
         mem_req = 1'b1;
         mem_addr = base + {12'h0, cur_q, word_q, 2'b00};
      end else if (state_q == S_DATA && !have_q) begin
         mem_req = 1'b1;
         mem_addr = dw0_q + {{(32 - COUNT_W){1'b0}}, off_q};
      end
   end

   assign tx_valid = state_q == S_DATA && have_q;
   assign tx_channel = chan;
   assign tx_last = last_buf && last_byte;
   assign dq_valid = state_q == S_DONE;
   assign dq_index = cur_q;
   assign dq_channel = chan;
   assign dq_status = status_q;

   // ****************************************************************
   // held chains and external links
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s0_valid_q <= 1'b0;
         s1_valid_q <= 1'b0;
         s0_index_q <= '0;
         s1_index_q <= '0;
         s0_ch_q <= 8'h0;
         s1_ch_q <= 8'h0;
         s0_restart_q <= 1'b0;
         s1_restart_q <= 1'b0;
         s0_check_q <= 1'b0;
         s1_check_q <= 1'b0;
         tail_q <= '0;
         link_index_q <= '0;
         link_restart_q <= 1'b0;
         ext_q <= 16'h0;
      end else if (pq_take) begin
         if (!s0_valid_q) begin
            s0_valid_q <= 1'b1;
            s0_index_q <= pq_index;
            s0_ch_q <= pq_channel;
            s0_restart_q <= pq_restart;
            s0_check_q <= 1'b1;
         end else if (!s1_valid_q && ext_q == 16'h0) begin
            s1_valid_q <= 1'b1;
            s1_index_q <= pq_index;
            s1_ch_q <= pq_channel;
            s1_restart_q <= pq_restart;
            s1_check_q <= 1'b1;
            tail_q <= pq_index;
         end else begin
            // third chain: kept in memory behind the newest one, restart flag travels in dword 3
            link_index_q <= pq_index;
            link_restart_q <= pq_restart;
         end
      end else if (state_q == S_LINK && mem_ack) begin
         tail_q <= link_index_q;
         ext_q <= ext_q + 16'h1;
      end else if (state_q == S_CHECK && first_q && !abort_q && dw3_q[`D3_LINK_VALID_BIT] && ext_q != 16'h0) begin
         // chain that was linked behind this one comes inside again; index counts only with link-valid set
         s1_valid_q <= 1'b1;
         s1_index_q <= dw3_q[15:0];
         s1_ch_q <= 8'h0;
         s1_restart_q <= dw3_q[`D3_RESTART_BIT];
         s1_check_q <= 1'b0;
         ext_q <= ext_q - 16'h1;
      end else if (state_q == S_START) begin
         s0_restart_q <= 1'b0;
      end else if (state_q == S_NEXT && (abort_q || (last_buf && !chain_next))) begin
         s0_valid_q <= s1_valid_q;
         s0_index_q <= s1_index_q;
         s0_ch_q <= s1_ch_q;
         s0_restart_q <= s1_restart_q;
         s0_check_q <= s1_check_q;
         s1_valid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // descriptor walk
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= S_IDLE;
         cur_q <= '0;
         word_q <= 2'h0;
         dw0_q <= 32'h0;
         dw1_q <= 32'h0;
         dw2_q <= 32'h0;
         dw3_q <= 32'h0;
         first_q <= 1'b0;
         check_q <= 1'b0;
         mid_q <= 1'b0;
         abort_q <= 1'b0;
         have_q <= 1'b0;
         post_q <= 1'b0;
         off_q <= '0;
         status_q <= `ST_PACKET_OK;
         tx_byte <= 8'h0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (pq_take) begin
                  if (s0_valid_q && (s1_valid_q || ext_q != 16'h0)) begin
                     state_q <= S_LINK;
                  end
               end else if (s0_valid_q) begin
                  state_q <= S_START;
               end
            end
            S_LINK: begin
               if (mem_ack) begin
                  state_q <= S_IDLE;
               end
            end
            S_START: begin
               cur_q <= s0_index_q;
               check_q <= s0_check_q;
               first_q <= 1'b1;
               mid_q <= 1'b0;
               abort_q <= 1'b0;
               word_q <= 2'h0;
               state_q <= S_READ;
            end
            S_READ: begin
               if (mem_ack) begin
                  if (mem_err) begin
                     status_q <= `ST_BUS_ERROR;
                     abort_q <= 1'b1;
                     state_q <= S_DONE;
                  end else begin
                     case (word_q)
                        2'h0: dw0_q <= mem_rdata;
                        2'h1: dw1_q <= mem_rdata;
                        2'h2: dw2_q <= mem_rdata;
                        default: dw3_q <= mem_rdata;
                     endcase
                     word_q <= word_q + 2'h1;
                     if (word_q == 2'h3) begin
                        state_q <= S_CHECK;
                     end
                  end
               end
            end
            S_CHECK: begin
               off_q <= '0;
               have_q <= 1'b0;
               if (!channel_enable_bit_q[chan]) begin
                  status_q <= `ST_NOT_ENABLED;
                  state_q <= S_DONE;
               end else if (count == '0 || (check_q && chan != s0_ch_q)) begin
                  status_q <= `ST_DESC_ERROR;
                  state_q <= S_DONE;
               end else begin
                  state_q <= S_DATA;
               end
            end
            S_DATA: begin
               if (!have_q && mem_ack && mem_err) begin
                  status_q <= `ST_BUS_ERROR;
                  state_q <= S_DONE;
               end else if (fifo_underflow) begin
                  status_q <= `ST_UNDERFLOW;
                  state_q <= S_DONE;
               end else if (!have_q && mem_ack) begin
                  tx_byte <= mem_rdata[{mem_addr[1:0], 3'b000} +: 8];
                  have_q <= 1'b1;
               end else if (have_q && tx_ready) begin
                  have_q <= 1'b0;
                  off_q <= off_q + 1'b1;
                  if (last_byte) begin
                     // buffer done: per-buffer mode posts every buffer, packet mode only the last
                     if (per_buffer_q) begin
                        status_q <= last_buf ? `ST_LAST_BUF : (mid_q ? `ST_MID_BUF : `ST_FIRST_BUF);
                     end else begin
                        status_q <= `ST_PACKET_OK;
                     end
                     post_q <= per_buffer_q || last_buf;
                     state_q <= (per_buffer_q || last_buf) ? S_DONE : S_NEXT;
                  end
               end
            end
            S_DONE: begin
               post_q <= 1'b0;
               if (dq_ready) begin
                  state_q <= S_NEXT;
               end
            end
            default: begin
               // S_NEXT: follow the buffer link, then the packet link, else end of chain
               first_q <= 1'b0;
               check_q <= 1'b0;
               word_q <= 2'h0;
               if (abort_q) begin
                  state_q <= S_IDLE;
               end else if (!last_buf) begin
                  cur_q <= dw1_q[15:0];
                  mid_q <= 1'b1;
                  state_q <= S_READ;
               end else if (chain_next) begin
                  cur_q <= dw1_q[15:0];
                  mid_q <= 1'b0;
                  state_q <= S_READ;
               end else begin
                  state_q <= S_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_bus_error_status: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == S_READ && mem_ack && mem_err) |=> dq_valid && dq_status == 3'h6)
      else $error("bus error not posted with status 110");

   a_underflow_status: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == S_DATA && fifo_underflow && !(mem_ack && mem_err && !have_q)) |=> dq_valid && dq_status == 3'h7)
      else $error("underflow not posted with status 111");

   a_disabled_skip: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == S_CHECK && !channel_enable_bit_q[chan]) |=> dq_valid && dq_status == 3'h4 && !tx_valid)
      else $error("descriptor of disabled channel not skipped with 100");

   a_error_disables: assert property (@(posedge clk_sys) disable iff (rst)
      ($rose(dq_valid) && dq_status[2] && !$past(reg_wr)) |-> !channel_enable_bit_q[dq_channel])
      else $error("errored descriptor posted while channel enabled");

   a_restart_enable: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == S_START && s0_restart_q) |=> channel_enable_bit_q[$past(s0_ch_q)] && state_q == S_READ)
      else $error("restart flag did not enable channel");

   a_zero_count: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == S_CHECK && channel_enable_bit_q[chan] && count == '0) |=> dq_status == 3'h5 ##1 !channel_enable_bit_q[$past(chan, 2)])
      else $error("zero byte count not treated as error");

   a_link_tail: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == S_LINK && mem_ack) |=> tail_q == $past(link_index_q) && ext_q == $past(ext_q) + 16'h1)
      else $error("external link not recorded");

   a_four_words: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == S_START) |=> state_q == S_READ && mem_addr[3:0] == 4'h0)
      else $error("descriptor fetch not quad-dword aligned");

endmodule : tx_dma_engine

/* tx_dma_map.svh */
// register offsets, descriptor field positions and done-queue status codes of the transmit descriptor engine
`ifndef TX_DMA_MAP_SVH
`define TX_DMA_MAP_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_BASE_LOW 12'h850
`define OFS_BASE_HIGH 12'h854
`define OFS_CHAN_ENABLE 12'h858
`define OFS_CONTROL 12'h85c
`define OFS_STATUS 12'h860
`define CHANNEL_ENABLE_BIT_VALUE_BIT 8
`define CTRL_PER_BUFFER_BIT 0
// ****************************************************************
// descriptor fields
// ****************************************************************
`define D1_LAST_BIT 31
`define D1_CHAIN_BIT 30
`define D1_COUNT_LSB 16
`define D1_COUNT_MSB 28
`define D3_LINK_VALID_BIT 16
`define D3_RESTART_BIT 17
`define DW3_OFFSET 4'hc
// ****************************************************************
// done-queue status codes
// ****************************************************************
`define ST_PACKET_OK 3'h0
`define ST_FIRST_BUF 3'h1
`define ST_MID_BUF 3'h2
`define ST_LAST_BUF 3'h3
`define ST_NOT_ENABLED 3'h4
`define ST_DESC_ERROR 3'h5
`define ST_BUS_ERROR 3'h6
`define ST_UNDERFLOW 3'h7
`endif

/* tx_dma_pkg.sv */
// types shared by the transmit descriptor engine
package tx_dma_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_LINK = 3'b001,
      S_START = 3'b010,
      S_READ = 3'b011,
      S_CHECK = 3'b100,
      S_DATA = 3'b101,
      S_DONE = 3'b110,
      S_NEXT = 3'b111
   } dma_state_t;
   typedef logic [15:0] desc_index_t;
   typedef logic [2:0] done_status_t;
endpackage : tx_dma_pkg

/* tx_host_mem.sv */
// host main memory model answering the engine's descriptor and data accesses
`timescale 1ns/1ps
module tx_host_mem (
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset
   input wire logic mem_req, // access wanted
   input wire logic mem_we, // write
   input wire logic [31:0] mem_addr, // byte address
   input wire logic [31:0] mem_wdata, // write data
   input wire logic [31:0] err_addr, // address that answers with a bus fault
   output logic mem_ack, // access complete
   output logic mem_err, // parity or abort
   output logic [31:0] mem_rdata // read data
);
   logic [31:0] mem [logic [31:0]];
   logic [3:0] lf_q;
   // a wandering delay, so the engine sees both prompt and slow answers
   always @(posedge clk_sys) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= ~mem_rdata;
      lf_q <= rst ? 4'h9 : {lf_q[2:0], lf_q[3] ^ lf_q[2]};
      if (!rst && mem_req && !mem_ack && lf_q[0]) begin
         mem_ack <= 1'b1;
         mem_err <= mem_addr == err_addr;
         if (mem_we) mem[{mem_addr[31:2], 2'b00}] = mem_wdata;
         else mem_rdata <= mem.exists({mem_addr[31:2], 2'b00}) ? mem[{mem_addr[31:2], 2'b00}] : 32'h0;
      end
   end
endmodule : tx_host_mem
